// [sysc_pkg.sv]
// Package: register map, field layout and reset values of the config bank
package sysc_pkg;
  localparam int IDX_W = 15;                         // Word index width
  localparam int DAT_W = 16;                         // Register width
  localparam int NPULL = 7;                          // Pull inhibit words
  // Register word indexes (byte address is four times the index)
  localparam logic [14:0] IDX_CLK_GATE_1 = 15'h1C02;
  localparam logic [14:0] IDX_CLK_GATE_2 = 15'h1C03;
  localparam logic [14:0] IDX_SLEW       = 15'h1C16;
  localparam logic [14:0] IDX_PULL_1     = 15'h1C17;
  localparam logic [14:0] IDX_PULL_2     = 15'h1C18;
  localparam logic [14:0] IDX_PULL_3     = 15'h1C19;
  localparam logic [14:0] IDX_PULL_4     = 15'h1C4C;
  localparam logic [14:0] IDX_PULL_5     = 15'h1C4D;
  localparam logic [14:0] IDX_PULL_6     = 15'h1C4F;
  localparam logic [14:0] IDX_PULL_7     = 15'h1C50;
  localparam logic [14:0] IDX_USB_SYS    = 15'h1C32;
  localparam logic [14:0] IDX_EXTMEM_SYS = 15'h1C33;
  localparam logic [14:0] IDX_BOOT_REC   = 15'h1C34;
  localparam logic [14:0] IDX_PIN_SEL    = 15'h1C00;
  localparam logic [14:0] IDX_REGULATOR  = 15'h7004;
  localparam logic [14:0] IDX_RTC_LO     = 15'h1900;
  localparam logic [14:0] IDX_RTC_HI     = 15'h197F;
  localparam logic [14:0] IDX_RTC_PWR    = 15'h1960;
  // Field positions
  localparam int PIN_SEL_A15 = 0;                    // Addr15 pin select
  localparam int PIN_SEL_A16 = 1;                    // Addr16 pin select
  localparam int REG_USB_EN  = 0;                    // USB regulator enable
  localparam int REG_VSEL    = 1;                    // Core voltage select
  localparam int USB_OSC_DIS = 2;                    // USB oscillator off
  localparam int SLEW_CLOCK_OUTPUT_PIN = 0;                    // Clock out slow slew
  localparam int SLEW_EXTMEM = 1;                    // Extmem slow slew
  // Reset values
  localparam logic [15:0] RST_PIN_SEL   = 16'h0003;
  localparam logic [15:0] RST_REGULATOR = 16'h0002;
  localparam logic [15:0] RST_USB_SYS   = 16'h0004;
  localparam logic [15:0] RST_EXTMEM    = 16'h0000;
  localparam logic [15:0] RST_SLEW      = 16'h0000;
  localparam logic [15:0] RST_PULL      = 16'h0000;
  localparam logic [15:0] RST_CLK_GATE  = 16'h0000;
  localparam logic [15:0] RST_RTC_PWR   = 16'h0000;
  // Timing: cycles from reset release to boot pin sample
  localparam logic [3:0]  BOOT_SAMPLE_CYCLES = 4'hA;
  // Byte lane codes
  localparam logic [1:0]  LANE_WORD = 2'h0;
  localparam logic [1:0]  LANE_HIGH = 2'h1;
  localparam logic [1:0]  LANE_LOW  = 2'h2;
  // Decoded configuration bundle
  typedef struct packed {
    logic        coreRegHighV;                       // 1.3 V when set
    logic        usbRegOn;                           // USB regulator on
    logic        usbOscOn;                           // USB oscillator on
    logic        sysRefExtClk;                       // Ref from ext clock
    logic [1:0]  extmemByteLane;                     // Extmem lane mode
    logic [1:0]  usbByteLane;                        // USB lane mode
    logic        slowSlewClkOut;                     // Clock out slow
    logic        slowSlewExtmem;                     // Extmem pins slow
    logic [15:0] clockGate1;                         // Clock gate word 1
    logic [15:0] clockGate2;                         // Clock gate word 2
    logic        busHolderEn;                        // Holder while off
  } sysc_cfg_t;
  // Boot state machine
  typedef enum logic [1:0] {
    BOOT_WAIT = 2'b00,
    BOOT_DONE = 2'b01
  } sysc_boot_t;
endpackage : sysc_pkg

// [sysc_config_regs.sv]
// Module: system configuration register bank on classic Wishbone
//
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ps
module sysc_config_regs #(
  parameter int ADDR_W = 17                          // Byte address width
) (
  input  wire logic                    clk,
  input  wire logic                    resetn,
  input  wire logic                    ce,
  input  wire logic [ADDR_W-1:0]       wbAdr,
  input  wire logic [31:0]             wbDatIn,
  input  wire logic [3:0]              wbSel,
  input  wire logic                    wbWe,
  input  wire logic                    wbCyc,
  input  wire logic                    wbStb,
  output logic [31:0]                  wbDatOut,
  output logic                         wbAck,
  input  wire logic                    clkSelPin,
  input  wire logic                    rtcOscOn,
  input  wire logic                    coreOff,
  input  wire logic [1:0]              extmemAddrHi,
  input  wire logic [1:0]              gpioOut,
  input  wire logic [1:0]              gpioDrive,
  input  wire logic [1:0]              padIn,
  output logic [1:0]                   padOut,
  output logic [1:0]                   padOutEnN,
  output logic [1:0]                   gpioIn,
  output logic [5:0]                   bootMethodRecord,
  output logic                         bootRecordValid,
  output logic [15:0]                  rtcPowerManagement,
  output logic [sysc_pkg::NPULL*16-1:0] pullEnable,
  output sysc_pkg::sysc_cfg_t          cfg
);
  import sysc_pkg::*;

  // Software visible registers
  logic [15:0] pinSel_reg;                           // Pin select word
  logic [15:0] regulator_reg;                        // Regulator control
  logic [15:0] usbSys_reg;                           // USB system control
  logic [15:0] extmemSys_reg;                        // Extmem control
  logic [15:0] slew_reg;                             // Slew control
  logic [15:0] gate1_reg;                            // Clock gate one
  logic [15:0] gate2_reg;                            // Clock gate two
  logic [15:0] rtcPwr_reg;                           // RTC power word
  logic [15:0] pull_reg [NPULL];                     // Pull inhibit words
  // Strap and boot capture
  logic        clkSel_reg;                           // Latched strap
  logic        strapDone_reg;                        // Strap caught
  logic [3:0]  bootCnt_reg;                          // Cycles since release
  logic [1:0]  bootPins_reg;                         // Sampled pin levels
  sysc_boot_t  boot_reg;                             // Boot sample state
  // Bus decode
  logic [IDX_W-1:0] idx;                             // Word index
  logic        req;                                  // New bus request
  logic        wrEn;                                 // Write this cycle
  logic        rtcHit;                               // In RTC window
  logic        rtcOk;                                // RTC window open
  logic [15:0] wdat;                                 // Byte merged data
  logic [15:0] rdat;                                 // Read mux
  logic [15:0] cur;                                  // Addressed word
  logic [2:0]  pullSlot;                             // Pull word number
  logic        pullHit;                              // Pull word hit

  assign idx    = wbAdr[ADDR_W-1:2];
  assign req    = ce && wbCyc && wbStb && !wbAck;
  assign wrEn   = req && wbWe;
  assign rtcHit = (idx >= IDX_RTC_LO) && (idx <= IDX_RTC_HI);
  assign rtcOk  = rtcOscOn;

  // Pull inhibit slot decode
  always_comb begin
    pullHit  = 1'b1;
    pullSlot = 3'h0;
    case (idx)
      IDX_PULL_1: pullSlot = 3'h0;
      IDX_PULL_2: pullSlot = 3'h1;
      IDX_PULL_3: pullSlot = 3'h2;
      IDX_PULL_4: pullSlot = 3'h3;
      IDX_PULL_5: pullSlot = 3'h4;
      IDX_PULL_6: pullSlot = 3'h5;
      IDX_PULL_7: pullSlot = 3'h6;
      default:    pullHit  = 1'b0;
    endcase
  end

  // Read mux; unmapped and blocked words read zero
  always_comb begin
    rdat = 16'h0000;
    case (idx)
      IDX_PIN_SEL:    rdat = pinSel_reg;
      IDX_REGULATOR:  rdat = regulator_reg;
      IDX_USB_SYS:    rdat = usbSys_reg;
      IDX_EXTMEM_SYS: rdat = extmemSys_reg;
      IDX_SLEW:       rdat = slew_reg;
      IDX_CLK_GATE_1: rdat = gate1_reg;
      IDX_CLK_GATE_2: rdat = gate2_reg;
      IDX_BOOT_REC:   rdat = {10'h000, bootMethodRecord};
      IDX_RTC_PWR:    rdat = rtcOk ? rtcPwr_reg : 16'h0000;
      default: begin
        if (pullHit) begin
          rdat = pull_reg[pullSlot];
        end
      end
    endcase
  end

  // Current word merged with enabled write bytes
  assign cur  = rdat;
  assign wdat = {wbSel[1] ? wbDatIn[15:8] : cur[15:8],
                 wbSel[0] ? wbDatIn[7:0]  : cur[7:0]};

  // Bus answer: one wait state, ack drops next enabled cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wbAck    <= 1'b0;
      wbDatOut <= 32'h0000_0000;
    end else if (ce) begin
      wbAck <= req;
      if (req && !wbWe) begin
        wbDatOut <= {16'h0000, rdat};
      end
    end
  end

  // Pin select word; gpio mode after reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pinSel_reg <= RST_PIN_SEL;
    end else if (wrEn && idx == IDX_PIN_SEL) begin
      pinSel_reg <= {14'h0000, wdat[1:0]};
    end
  end

  // Regulator word: enable and voltage select
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      regulator_reg <= RST_REGULATOR;
    end else if (wrEn && idx == IDX_REGULATOR) begin
      regulator_reg <= {14'h0000, wdat[1:0]};
    end
  end

  // USB system word: lane field and oscillator off bit
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      usbSys_reg <= RST_USB_SYS;
    end else if (wrEn && idx == IDX_USB_SYS) begin
      usbSys_reg <= {13'h0000, wdat[2:0]};
    end
  end

  // Extmem system word: lane field
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      extmemSys_reg <= RST_EXTMEM;
    end else if (wrEn && idx == IDX_EXTMEM_SYS) begin
      extmemSys_reg <= {14'h0000, wdat[1:0]};
    end
  end

  // Slew word and clock gate words
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      slew_reg  <= RST_SLEW;
      gate1_reg <= RST_CLK_GATE;
      gate2_reg <= RST_CLK_GATE;
    end else if (wrEn) begin
      if (idx == IDX_SLEW) begin
        slew_reg <= {14'h0000, wdat[1:0]};
      end
      if (idx == IDX_CLK_GATE_1) begin
        gate1_reg <= wdat;
      end
      if (idx == IDX_CLK_GATE_2) begin
        gate2_reg <= wdat;
      end
    end
  end

  // RTC power word, writable only while oscillator runs
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rtcPwr_reg <= RST_RTC_PWR;
    end else if (wrEn && idx == IDX_RTC_PWR && rtcHit && rtcOk) begin
      rtcPwr_reg <= wdat;
    end
  end

  // Pull inhibit words, all pulls on after reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NPULL; i++) begin
        pull_reg[i] <= RST_PULL;
      end
    end else if (wrEn && pullHit) begin
      pull_reg[pullSlot] <= wdat;
    end
  end

  // Strap caught at first enabled edge after release
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      clkSel_reg    <= 1'b1;
      strapDone_reg <= 1'b0;
    end else if (ce && !strapDone_reg) begin
      clkSel_reg    <= clkSelPin;
      strapDone_reg <= 1'b1;
    end
  end

  // Boot pin sample after fixed delay
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      boot_reg     <= BOOT_WAIT;
      bootCnt_reg  <= 4'h0;
      bootPins_reg <= 2'h0;
      bootRecordValid <= 1'b0;                       // No record before sample
    end else if (ce) begin
      case (boot_reg)
        BOOT_WAIT: begin
          bootCnt_reg <= bootCnt_reg + 4'h1;
          if (bootCnt_reg == BOOT_SAMPLE_CYCLES - 4'h1) begin
            bootPins_reg <= padIn;
            boot_reg     <= BOOT_DONE;
            // Valid flag kept in its own flop for a clean output
            bootRecordValid <= 1'b1;
          end
        end
        BOOT_DONE: begin
          bootCnt_reg <= bootCnt_reg;
        end
        default: begin
          boot_reg <= BOOT_WAIT;
        end
      endcase
    end
  end

  assign bootMethodRecord = {4'h0, bootPins_reg};
  assign rtcPowerManagement = rtcPwr_reg;

  // Shared pad routing, registered
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      padOut    <= 2'h0;
      padOutEnN <= 2'h3;
      gpioIn    <= 2'h0;
    end else if (ce) begin
      for (int p = 0; p < 2; p++) begin
        if (pinSel_reg[p]) begin
          // Gpio function: gpio block owns direction
          padOut[p]    <= gpioOut[p];
          padOutEnN[p] <= !gpioDrive[p];
          gpioIn[p]    <= padIn[p];
        end else begin
          // Address function: always driven
          padOut[p]    <= extmemAddrHi[p];
          padOutEnN[p] <= 1'b0;
          gpioIn[p]    <= 1'b0;
        end
      end
    end
  end

  // Decoded configuration outputs
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg <= '0;
      cfg.coreRegHighV <= 1'b1;
      cfg.sysRefExtClk <= 1'b1;
    end else if (ce) begin
      cfg.coreRegHighV <= regulator_reg[REG_VSEL];
      // Strap low keeps USB regulator on
      cfg.usbRegOn <= !clkSel_reg || regulator_reg[REG_USB_EN];
      // Strap low keeps USB oscillator on
      cfg.usbOscOn <= !clkSel_reg || !usbSys_reg[USB_OSC_DIS];
      cfg.sysRefExtClk   <= clkSel_reg;
      cfg.extmemByteLane <= extmemSys_reg[1:0];
      cfg.usbByteLane    <= usbSys_reg[1:0];
      cfg.slowSlewClkOut <= slew_reg[SLEW_CLOCK_OUTPUT_PIN];
      cfg.slowSlewExtmem <= slew_reg[SLEW_EXTMEM];
      cfg.clockGate1     <= gate1_reg;
      cfg.clockGate2     <= gate2_reg;
      cfg.busHolderEn    <= coreOff;
    end
  end

  // Pull enables, forced off while core is down
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pullEnable <= '1;
    end else if (ce) begin
      for (int k = 0; k < NPULL; k++) begin
        pullEnable[k*16 +: 16] <= coreOff ? 16'h0000 : ~pull_reg[k];
      end
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_req;
    wbCyc && wbStb && !wbAck && ce;
  endsequence
  sequence s_ack;
    // Ack lingers only while the clock enable is low
    wbAck ##1 (!wbAck || !$past(ce));
  endsequence
  property p_ack;
    s_req |=> s_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("bus ack missing");

  property p_addr16;
    (ce && !pinSel_reg[PIN_SEL_A16]) |=> !padOutEnN[1] && padOut[1] == $past(extmemAddrHi[1]);
  endproperty
  a_addr16: assert property (p_addr16) else $error("addr16 not routed");

  property p_gpio21;
    (ce && pinSel_reg[PIN_SEL_A15]) |=> gpioIn[0] == $past(padIn[0]);
  endproperty
  a_gpio21: assert property (p_gpio21) else $error("gpio21 not routed");

  property p_boot;
    $rose(bootRecordValid) |-> bootPins_reg == $past(padIn) && bootCnt_reg == BOOT_SAMPLE_CYCLES;
  endproperty
  a_boot: assert property (p_boot) else $error("boot sample wrong");

  property p_usbreg;
    (ce && strapDone_reg && !clkSel_reg) |=> cfg.usbRegOn && cfg.usbOscOn;
  endproperty
  a_usbreg: assert property (p_usbreg) else $error("usb supply off");

  property p_osc;
    (ce && clkSel_reg) |=> cfg.usbOscOn == !$past(usbSys_reg[USB_OSC_DIS]);
  endproperty
  a_osc: assert property (p_osc) else $error("usb osc wrong");

  property p_pull;
    (ce && coreOff) |=> pullEnable == '0 && cfg.busHolderEn;
  endproperty
  a_pull: assert property (p_pull) else $error("pull not forced");

  property p_rtc;
    (wrEn && rtcHit && !rtcOk) |=> $stable(rtcPwr_reg);
  endproperty
  a_rtc: assert property (p_rtc) else $error("rtc write leaked");

  property p_lane;
    (wrEn && idx == IDX_EXTMEM_SYS && wbSel[0]) |=> ##1 (!$past(ce) ||
      cfg.extmemByteLane == $past(wbDatIn[1:0], 2));
  endproperty
  a_lane: assert property (p_lane) else $error("lane mode wrong");

  // USB lane field reaches the decoded bundle one edge later
  property p_usblane;
    ce |=> cfg.usbByteLane == $past(usbSys_reg[1:0]);
  endproperty
  a_usblane: assert property (p_usblane) else $error("usb lane wrong");

endmodule : sysc_config_regs

// [testbench.sv]
// Self-checking bench for the system configuration register bank
`timescale 1ns/1ps
module testbench;
  import sysc_pkg::*;
  logic                clk;                 // System clock
  logic                resetn;              // Async reset, active low
  logic                ce;                  // Clock enable
  logic [16:0]         wbAdr;               // Byte address
  logic [31:0]         wbDatIn;             // Write data
  logic [3:0]          wbSel;               // Byte enables
  logic                wbWe;                // Write strobe
  logic                wbCyc;               // Bus cycle
  logic                wbStb;               // Bus strobe
  logic [31:0]         wbDatOut;            // Read data
  logic                wbAck;               // Bus acknowledge
  logic                clkSelPin;           // Clock-select strap
  logic                rtcOscOn;            // RTC oscillator running
  logic                coreOff;             // Core power down
  logic [1:0]          extmemAddrHi;        // Ext address 15 and 16
  logic [1:0]          gpioOut;             // Gpio output values
  logic [1:0]          gpioDrive;           // Gpio drive requests
  logic [1:0]          padIn;               // Pad levels
  logic [1:0]          padOut;              // Pad outputs
  logic [1:0]          padOutEnN;           // Pad enables, low drives
  logic [1:0]          gpioIn;              // Pad level to gpio
  logic [5:0]          bootMethodRecord;    // Sampled boot pins
  logic                bootRecordValid;     // Boot sample taken
  logic [15:0]         rtcPowerManagement;  // RTC power word
  logic [NPULL*16-1:0] pullEnable;          // Pull enables
  sysc_cfg_t           cfg;                 // Decoded configuration
  int                  mismatches;          // Failed compares
  int                  tests_run;           // Compares made
  logic [31:0]         rd;                  // Last read value
  logic [1:0]          expEn;               // Expected pad enables
  logic [1:0]          expOut;              // Expected pad outputs
  logic [1:0]          expGi;               // Expected gpio inputs
  logic [3:0]          wrSel;               // Byte enables for writes
  logic [14:0]         pullIdx [7] = '{IDX_PULL_1, IDX_PULL_2, IDX_PULL_3, IDX_PULL_4,
                                       IDX_PULL_5, IDX_PULL_6, IDX_PULL_7};

  sysc_config_regs u_dut (
    .clk(clk), .resetn(resetn), .ce(ce), .wbAdr(wbAdr), .wbDatIn(wbDatIn),
    .wbSel(wbSel), .wbWe(wbWe), .wbCyc(wbCyc), .wbStb(wbStb), .wbDatOut(wbDatOut),
    .wbAck(wbAck), .clkSelPin(clkSelPin), .rtcOscOn(rtcOscOn), .coreOff(coreOff),
    .extmemAddrHi(extmemAddrHi), .gpioOut(gpioOut), .gpioDrive(gpioDrive),
    .padIn(padIn), .padOut(padOut), .padOutEnN(padOutEnN), .gpioIn(gpioIn),
    .bootMethodRecord(bootMethodRecord), .bootRecordValid(bootRecordValid),
    .rtcPowerManagement(rtcPowerManagement), .pullEnable(pullEnable), .cfg(cfg)
  );

  // Free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Compare one value, count and report a difference
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Verdict and end of run
  task automatic report_and_stop;
    $display("Compares %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // One classic bus cycle; held until ack is sampled high
  task automatic wb_access(input logic [14:0] idx, input logic we, input logic [15:0] dat);
    @(posedge clk);
    wbAdr   <= {idx, 2'b00};
    wbWe    <= we;
    wbDatIn <= {16'h0000, dat};
    wbSel   <= wrSel;
    wbCyc   <= 1'b1;
    wbStb   <= 1'b1;
    do begin
      @(posedge clk);
    end while (wbAck !== 1'b1);
    check("bus ack", wbAck, 1);
    rd = wbDatOut;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe  <= 1'b0;
  endtask : wb_access

  // Read a register and compare its low word
  task automatic rd_check(input string name, input logic [14:0] idx, input logic [15:0] exp);
    wb_access(idx, 1'b0, 16'h0000);
    check(name, rd, {16'h0000, exp});
  endtask : rd_check

  // Let registered outputs follow the registers
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  // Reset with a static strap, then watch the boot sample land
  task automatic do_reset(input logic strap, input logic [1:0] pads);
    @(posedge clk);
    resetn    <= 1'b0;
    clkSelPin <= strap;
    padIn     <= pads;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    repeat (9) @(posedge clk);
    #1;
    check("boot valid early", bootRecordValid, 0);
    @(posedge clk);
    #1;
    check("boot valid", bootRecordValid, 1);
    check("boot record", bootMethodRecord, {4'h0, pads});
  endtask : do_reset

  // Watchdog against a hung handshake
  initial begin
    #100000;
    mismatches++;
    report_and_stop;
  end

  // Main sequence
  initial begin
    resetn = 1'b0; ce = 1'b1; wbAdr = '0; wbDatIn = '0; wbSel = '0;
    wbWe = 1'b0; wbCyc = 1'b0; wbStb = 1'b0; clkSelPin = 1'b1; rtcOscOn = 1'b0;
    coreOff = 1'b0; extmemAddrHi = 2'b01; gpioOut = 2'b10; gpioDrive = 2'b00;
    padIn = 2'b10; mismatches = 0; tests_run = 0;
    wrSel = 4'h3;
    do_reset(1'b1, 2'b10);
    check("pads as inputs", padOutEnN, 2'b11);
    check("gpio in at reset", gpioIn, 2'b10);
    rd_check("pin select reset", IDX_PIN_SEL, RST_PIN_SEL);
    padIn <= 2'b01;
    settle();
    check("boot record held", bootMethodRecord, 6'h02);
    wb_access(IDX_BOOT_REC, 1'b1, 16'h003F);
    rd_check("boot record read", IDX_BOOT_REC, 16'h0002);
    // Gpio side now asks to drive pad zero
    gpioDrive <= 2'b01;
    // Every pin select combination, upper bits not stored
    for (int m = 0; m < 4; m++) begin
      wb_access(IDX_PIN_SEL, 1'b1, 16'(m) | 16'hFFFC);
      settle();
      for (int b = 0; b < 2; b++) begin
        expEn[b]  = m[b] ? ~gpioDrive[b] : 1'b0;
        expOut[b] = m[b] ? gpioOut[b] : extmemAddrHi[b];
        expGi[b]  = m[b] ? padIn[b] : 1'b0;
      end
      check("pad enables", padOutEnN, expEn);
      check("pad out", padOut & ~expEn, expOut & ~expEn);
      check("gpio in", gpioIn, expGi);
      rd_check("pin select", IDX_PIN_SEL, 16'(m));
    end
    // Regulator and oscillator with strap high
    rd_check("regulator reset", IDX_REGULATOR, RST_REGULATOR);
    rd_check("usb sys reset", IDX_USB_SYS, RST_USB_SYS);
    check("core high v", cfg.coreRegHighV, 1);
    check("usb reg off", cfg.usbRegOn, 0);
    check("usb osc off", cfg.usbOscOn, 0);
    check("ext clock ref", cfg.sysRefExtClk, 1);
    wb_access(IDX_REGULATOR, 1'b1, 16'h0001);
    wb_access(IDX_USB_SYS, 1'b1, 16'h0000);
    settle();
    check("core low v", cfg.coreRegHighV, 0);
    check("usb reg on", cfg.usbRegOn, 1);
    check("usb osc on", cfg.usbOscOn, 1);
    // Byte lane codes for both spaces
    rd_check("extmem reset", IDX_EXTMEM_SYS, RST_EXTMEM);
    for (int l = 0; l < 3; l++) begin
      wb_access(IDX_EXTMEM_SYS, 1'b1, 16'(l));
      wb_access(IDX_USB_SYS, 1'b1, 16'(l) | 16'h0004);
      settle();
      check("extmem lane", cfg.extmemByteLane, l[1:0]);
      check("usb lane", cfg.usbByteLane, l[1:0]);
      check("usb osc switched off", cfg.usbOscOn, 0);
    end
    // Pull inhibit words, each its own pattern
    for (int k = 0; k < NPULL; k++) begin
      check("pull reset", pullEnable[16*k +: 16], 16'hFFFF);
      wb_access(pullIdx[k], 1'b1, 16'h0101 << k);
      settle();
      check("pull word", pullEnable[16*k +: 16], 16'(~(16'h0101 << k)));
      rd_check("pull read", pullIdx[k], 16'h0101 << k);
    end
    // Clock enable low: core-off must not reach the outputs yet
    @(posedge clk);
    ce      <= 1'b0;
    coreOff <= 1'b1;
    settle();
    check("pulls frozen", pullEnable[15:0], 16'hFEFE);
    check("holder frozen", cfg.busHolderEn, 0);
    @(posedge clk);
    ce <= 1'b1;
    settle();
    check("pulls forced off", pullEnable[31:0], 0);
    check("pulls forced off hi", pullEnable[111:80], 0);
    check("bus holder", cfg.busHolderEn, 1);
    @(posedge clk);
    coreOff <= 1'b0;
    // Slew selections
    for (int s = 0; s < 4; s++) begin
      wb_access(IDX_SLEW, 1'b1, 16'(s));
      settle();
      check("slew clock out", cfg.slowSlewClkOut, s[0]);
      check("slew extmem", cfg.slowSlewExtmem, s[1]);
    end
    wb_access(IDX_CLK_GATE_1, 1'b1, 16'hA5C3);
    rd_check("clock gate one", IDX_CLK_GATE_1, 16'hA5C3);
    // High byte only, low byte kept
    wrSel = 4'h2;
    wb_access(IDX_CLK_GATE_1, 1'b1, 16'h0FF0);
    wrSel = 4'h3;
    rd_check("clock gate high byte", IDX_CLK_GATE_1, 16'h0FC3);
    wb_access(IDX_CLK_GATE_2, 1'b1, 16'h5A3C);
    settle();
    check("clock gate out one", cfg.clockGate1, 16'h0FC3);
    check("clock gate out two", cfg.clockGate2, 16'h5A3C);
    // RTC window blocked, then open
    wb_access(IDX_RTC_PWR, 1'b1, 16'h1234);
    rd_check("rtc blocked", IDX_RTC_PWR, 16'h0000);
    check("rtc word blocked", rtcPowerManagement, 0);
    @(posedge clk);
    rtcOscOn <= 1'b1;
    wb_access(IDX_RTC_PWR, 1'b1, 16'h1234);
    rd_check("rtc open", IDX_RTC_PWR, 16'h1234);
    settle();
    check("rtc word", rtcPowerManagement, 16'h1234);
    rd_check("unmapped", 15'h0100, 16'h0000);
    // Second reset with strap low
    do_reset(1'b0, 2'b01);
    check("usb osc ref", cfg.sysRefExtClk, 0);
    wb_access(IDX_REGULATOR, 1'b1, 16'h0000);
    wb_access(IDX_USB_SYS, 1'b1, 16'h0004);
    settle();
    check("usb reg stays on", cfg.usbRegOn, 1);
    check("usb osc stays on", cfg.usbOscOn, 1);
    check("core low v again", cfg.coreRegHighV, 0);
    rd_check("pin select reset again", IDX_PIN_SEL, RST_PIN_SEL);
    report_and_stop;
  end
endmodule : testbench
